// *** rtl/clock_status_pkg.sv ***
// constants, field layouts and carriers for the clock status block
// Operation
// - one in pending_clear clears that pending flag
// - status bit 31 shows access error occurred
// - bits 6/5 flag synth lock dropped
// - bit 4 set while brownout enabled and low
// - bits 3/2 show synth1/synth0 locked
// - bit 1 shows slow oscillator ready
// - bit 0 shows main oscillator ready
// - unlock holds key high byte, 10-bit address
// - lock flag waits programmed slow-clock count
// - vco ratio (mul+1)/div, or 2(mul+1)
// - option bit 1 halves synth output
// - input divider div zero ones, else 2div
// - option bit 0 selects oscillator range
// - option bit 2 clear enables wide bandwidth
// - source 0 routes osc0; enable bit switches
// - pending flag set by event, held till cleared
// - mask set/clear registers; only masked interrupt
package clock_status_pkg;

    ////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [9:0] OFS_MASK_SET = 10'h000;
    localparam logic [9:0] OFS_MASK_CLEAR = 10'h004;
    localparam logic [9:0] OFS_MASK = 10'h008;
    localparam logic [9:0] OFS_PENDING = 10'h00C;
    localparam logic [9:0] OFS_PENDING_CLEAR = 10'h010;
    localparam logic [9:0] OFS_STATUS = 10'h014;
    localparam logic [9:0] OFS_UNLOCK = 10'h018;
    localparam logic [9:0] OFS_SYNTH0 = 10'h01C;
    localparam logic [9:0] OFS_SYNTH1 = 10'h020;

    ////////////////////////////////////////////////////////////////
    // flag bit positions and reset values
    localparam int BIT_ACCESS_ERROR = 31;
    localparam int BIT_SYNTH1_LOST = 6;
    localparam int BIT_SYNTH0_LOST = 5;
    localparam int BIT_BROWNOUT = 4;
    localparam int BIT_SYNTH1_LOCK = 3;
    localparam int BIT_SYNTH0_LOCK = 2;
    localparam int BIT_SLOW_OSC = 1;
    localparam int BIT_MAIN_OSC = 0;
    localparam logic [31:0] FLAG_MASK = 32'h8000007F;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    ////////////////////////////////////////////////////////////////
    // unlock and synth control field positions
    localparam logic [7:0] UNLOCK_KEY = 8'hAA;
    localparam int KEY_LSB = 24;
    localparam int CNT_LSB = 24;
    localparam int MUL_LSB = 16;
    localparam int DIV_LSB = 8;
    localparam int OPT_LSB = 3;
    localparam int SRC_LSB = 1;
    localparam int EN_BIT = 0;
    localparam logic [1:0] SRC_OSC0 = 2'h0;

    typedef struct packed {
        logic sel;
        logic write;
        logic [9:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [5:0] count;
        logic [3:0] mul;
        logic [3:0] div;
        logic [2:0] opt;
        logic [1:0] src;
        logic en;
    } synth_ctrl_t;

    // settings driven to the analog synthesiser
    typedef struct packed {
        logic en;
        logic src_osc0;
        logic range_high;
        logic out_halve;
        logic wide_bw;
        logic [5:0] vco_num;
        logic [3:0] vco_den;
        logic [4:0] in_div;
    } synth_out_t;

endpackage : clock_status_pkg

// *** rtl/clock_status_pll_control.sv ***
// clock status, interrupt flags, unlock guard and synth control
module clock_status_pll_control (
    input wire logic core_clk,
    input wire logic rst,
    input wire clock_status_pkg::bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input wire logic main_osc_ready,
    input wire logic slow_osc_ready,
    input wire logic brownout_enabled,
    input wire logic supply_below,
    input wire logic slow_tick,
    input wire logic [1:0] synth_fault,
    input wire logic [1:0] sleep_reenable,
    output clock_status_pkg::synth_out_t [1:0] synth_cfg,
    output logic irq
);

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] pending;
        logic [31:0] status_prev;
        logic access_error;
        logic armed;
        logic [9:0] unlock_addr;
        clock_status_pkg::synth_ctrl_t [1:0] ctrl;
        logic [1:0][5:0] cnt;
        logic [1:0] locked;
        logic [1:0] lost;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////
    // field packing helpers
    function automatic logic [31:0] pack_ctrl(
        input clock_status_pkg::synth_ctrl_t c
    );
        logic [31:0] w;
        w = clock_status_pkg::RESET_WORD;
        w[clock_status_pkg::CNT_LSB +: 6] = c.count;
        w[clock_status_pkg::MUL_LSB +: 4] = c.mul;
        w[clock_status_pkg::DIV_LSB +: 4] = c.div;
        w[clock_status_pkg::OPT_LSB +: 3] = c.opt;
        w[clock_status_pkg::SRC_LSB +: 2] = c.src;
        w[clock_status_pkg::EN_BIT] = c.en;
        return w;
    endfunction : pack_ctrl

    function automatic clock_status_pkg::synth_ctrl_t unpack_ctrl(
        input logic [31:0] w
    );
        clock_status_pkg::synth_ctrl_t c;
        c.count = w[clock_status_pkg::CNT_LSB +: 6];
        c.mul = w[clock_status_pkg::MUL_LSB +: 4];
        c.div = w[clock_status_pkg::DIV_LSB +: 4];
        c.opt = w[clock_status_pkg::OPT_LSB +: 3];
        c.src = w[clock_status_pkg::SRC_LSB +: 2];
        c.en = w[clock_status_pkg::EN_BIT];
        return c;
    endfunction : unpack_ctrl

    // ratio and option decode for the analog synthesiser
    function automatic clock_status_pkg::synth_out_t decode_ctrl(
        input clock_status_pkg::synth_ctrl_t c
    );
        clock_status_pkg::synth_out_t o;
        logic [5:0] m1;
        m1 = {2'h0, c.mul} + 6'h01;
        o.en = c.en;
        o.src_osc0 = (c.src == clock_status_pkg::SRC_OSC0);
        o.range_high = c.opt[0];
        o.out_halve = c.opt[1];
        o.wide_bw = ~c.opt[2];
        if (c.div == 4'h0) begin
            o.vco_num = 6'(m1 << 1);
            o.vco_den = 4'h1;
            o.in_div = 5'h01;
        end else begin
            o.vco_num = m1;
            o.vco_den = c.div;
            o.in_div = {c.div, 1'b0};
        end
        return o;
    endfunction : decode_ctrl

    // lock timer of one synthesiser, kept as one small carrier
    typedef struct packed {
        logic [5:0] cnt;
        logic locked;
        logic lost;
    } timer_t;

    // one clock step of a lock timer; a restart, a fault or a cleared
    // enable reloads the count, so a lock is never reported before the
    // full programmed wait has run from the latest change
    function automatic timer_t step_timer(
        input timer_t t,
        input logic restart_i,
        input logic fault_i,
        input logic en_i,
        input logic [5:0] count_i,
        input logic tick_i
    );
        timer_t n;
        n = t;
        // a fresh start forgets an earlier loss
        if (restart_i) begin
            n.lost = 1'b0;
        end
        // reload while held off, count slow ticks otherwise
        if (restart_i || fault_i || !en_i) begin
            n.locked = 1'b0;
            n.cnt = count_i;
        end else if (!t.locked) begin
            if (t.cnt == 6'h00) begin
                n.locked = 1'b1;
            end else if (tick_i) begin
                n.cnt = 6'(t.cnt - 6'h01);
            end
        end
        // any fall of the lock, disable included, marks a loss
        if (t.locked && !n.locked) begin
            n.lost = 1'b1;
        end
        return n;
    endfunction : step_timer

    // read mux over the mapped words; write-only words and holes
    // read as zero so that software never sees stale bus data
    function automatic logic [31:0] read_word(
        input logic [9:0] addr,
        input state_t s,
        input logic [31:0] status
    );
        logic [31:0] w;
        w = clock_status_pkg::RESET_WORD;
        case (addr)
            clock_status_pkg::OFS_MASK: w = s.mask;
            clock_status_pkg::OFS_PENDING: w = s.pending;
            clock_status_pkg::OFS_STATUS: w = status;
            clock_status_pkg::OFS_SYNTH0: w = pack_ctrl(s.ctrl[0]);
            clock_status_pkg::OFS_SYNTH1: w = pack_ctrl(s.ctrl[1]);
            default: w = clock_status_pkg::RESET_WORD;
        endcase
        return w;
    endfunction : read_word

    // unlock word decode: key match in the top bit, target offset below;
    // the offset is kept whole so a mismatched target never unlocks
    function automatic logic [10:0] unlock_target(
        input logic [31:0] w
    );
        logic key_ok;
        logic [9:0] target;
        key_ok = (w[clock_status_pkg::KEY_LSB +: 8] ==
            clock_status_pkg::UNLOCK_KEY);
        target = {w[9:8], w[7:0]};
        return {key_ok, target};
    endfunction : unlock_target

    // live status word: error, loss, brownout, lock and ready bits, rest zero
    function automatic logic [31:0] status_word(
        input state_t s,
        input logic bod,
        input logic slow_ready,
        input logic main_ready
    );
        logic [31:0] w;
        w = clock_status_pkg::RESET_WORD;
        w[clock_status_pkg::BIT_ACCESS_ERROR] = s.access_error;
        w[clock_status_pkg::BIT_SYNTH1_LOST] = s.lost[1];
        w[clock_status_pkg::BIT_SYNTH0_LOST] = s.lost[0];
        w[clock_status_pkg::BIT_BROWNOUT] = bod;
        w[clock_status_pkg::BIT_SYNTH1_LOCK] = s.locked[1];
        w[clock_status_pkg::BIT_SYNTH0_LOCK] = s.locked[0];
        w[clock_status_pkg::BIT_SLOW_OSC] = slow_ready;
        w[clock_status_pkg::BIT_MAIN_OSC] = main_ready;
        return w;
    endfunction : status_word

    ////////////////////////////////////////////////////////////////
    // live status word
    logic [31:0] status_now;
    logic bod_active;

    assign bod_active = brownout_enabled & supply_below;

    // status bits from the timers, the error flag and the pins
    assign status_now = status_word(s_q, bod_active, slow_osc_ready,
        main_osc_ready);

    ////////////////////////////////////////////////////////////////
    // next state
    logic hit;
    logic wr;
    logic guard_ok;
    logic ae_evt;
    logic [31:0] clr;
    logic [31:0] events;
    logic [1:0] restart;
    logic [10:0] key_hit;
    timer_t tmr;

    always_comb begin
        s_d = s_q;
        hit = bus_req.sel;
        wr = bus_req.sel & bus_req.write;
        guard_ok = s_q.armed && (s_q.unlock_addr == bus_req.addr);
        ae_evt = 1'b0;
        clr = clock_status_pkg::RESET_WORD;
        restart = sleep_reenable;
        key_hit = unlock_target(bus_req.wdata);
        tmr = '0;

        // any bus access consumes the unlock
        if (hit) begin
            s_d.armed = 1'b0;
        end

        // read mux, answered one cycle later
        s_d.rdata = clock_status_pkg::RESET_WORD;
        if (hit && !bus_req.write) begin
            s_d.rdata = read_word(bus_req.addr, s_q, status_now);
        end

        // register writes
        if (wr) begin
            case (bus_req.addr)
                // mask set and clear, one bit per source
                clock_status_pkg::OFS_MASK_SET: begin
                    s_d.mask = s_q.mask |
                        (bus_req.wdata & clock_status_pkg::FLAG_MASK);
                end
                clock_status_pkg::OFS_MASK_CLEAR: begin
                    s_d.mask = s_q.mask & ~bus_req.wdata;
                end
                clock_status_pkg::OFS_PENDING_CLEAR: begin
                    clr = bus_req.wdata & clock_status_pkg::FLAG_MASK;
                end
                // keyed unlock arms the guard for the next access
                clock_status_pkg::OFS_UNLOCK: begin
                    if (key_hit[10]) begin
                        s_d.armed = 1'b1;
                        s_d.unlock_addr = key_hit[9:0];
                    end
                end
                // protected control words, refused unless armed
                clock_status_pkg::OFS_SYNTH0: begin
                    if (guard_ok) begin
                        s_d.ctrl[0] = unpack_ctrl(bus_req.wdata);
                        restart[0] = 1'b1;
                    end else begin
                        ae_evt = 1'b1;
                    end
                end
                clock_status_pkg::OFS_SYNTH1: begin
                    if (guard_ok) begin
                        s_d.ctrl[1] = unpack_ctrl(bus_req.wdata);
                        restart[1] = 1'b1;
                    end else begin
                        ae_evt = 1'b1;
                    end
                end
                default: s_d.mask = s_d.mask;
            endcase
        end

        // lock timers per synthesiser
        for (int i = 0; i < 2; i++) begin
            tmr = step_timer({s_q.cnt[i], s_q.locked[i], s_q.lost[i]},
                restart[i], synth_fault[i], s_d.ctrl[i].en,
                s_d.ctrl[i].count, slow_tick);
            s_d.cnt[i] = tmr.cnt;
            s_d.locked[i] = tmr.locked;
            s_d.lost[i] = tmr.lost;
        end

        // access error status, set wins over clear
        if (clr[clock_status_pkg::BIT_ACCESS_ERROR]) begin
            s_d.access_error = 1'b0;
        end
        if (ae_evt) begin
            s_d.access_error = 1'b1;
        end

        // pending flags on rising status bits, set wins
        events = status_now & ~s_q.status_prev & clock_status_pkg::FLAG_MASK;
        events[clock_status_pkg::BIT_ACCESS_ERROR] = ae_evt;
        s_d.status_prev = status_now;
        s_d.pending = (s_q.pending & ~clr) | events;
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign bus_rdata = s_q.rdata;
    assign irq = |(s_q.pending & s_q.mask);
    assign synth_cfg[0] = decode_ctrl(s_q.ctrl[0]);
    assign synth_cfg[1] = decode_ctrl(s_q.ctrl[1]);

endmodule : clock_status_pll_control

// *** test/clock_status_pll_control_properties.sv ***
// port-level assertions for the clock status block
module clock_status_pll_control_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire clock_status_pkg::bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic main_osc_ready,
    input wire logic slow_osc_ready,
    input wire logic brownout_enabled,
    input wire logic supply_below,
    input wire clock_status_pkg::synth_out_t [1:0] synth_cfg,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // last access was a keyed unlock, and the ratio it should decode to
    logic ulk_q, rd, wr, ok0, bad0;
    logic [9:0] ulk_addr_q;
    logic [3:0] dv;
    logic [4:0] m1;
    assign rd = bus_req.sel && !bus_req.write;
    assign wr = bus_req.sel && bus_req.write;
    assign ok0 = wr && bus_req.addr == 10'h01C && ulk_q &&
        ulk_addr_q == 10'h01C;
    assign bad0 = wr && bus_req.addr == 10'h01C && !ok0;
    assign dv = bus_req.wdata[11:8];
    assign m1 = {1'b0, bus_req.wdata[19:16]} + 5'h01;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ulk_q <= 1'b0;
        end else if (bus_req.sel) begin
            ulk_q <= wr && bus_req.addr == 10'h018 &&
                bus_req.wdata[31:24] == 8'hAA;
            ulk_addr_q <= bus_req.wdata[9:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    osc_ready_a: assert property (
        rd && bus_req.addr == 10'h014 && !$past(rst) &&
        $stable({main_osc_ready, slow_osc_ready}) |=>
        bus_rdata[1:0] == $past({slow_osc_ready, main_osc_ready}))
        else $error("oscillator ready bits wrong");
    brownout_flag_a: assert property (
        rd && bus_req.addr == 10'h014 && !$past(rst) &&
        $stable({brownout_enabled, supply_below}) |=>
        bus_rdata[4] == $past(brownout_enabled && supply_below))
        else $error("brownout bit wrong");
    wo_read_a: assert property (
        rd && bus_req.addr inside {10'h010, 10'h018, 10'h024} |=>
        bus_rdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    blocked_write_a: assert property (
        bad0 |=> $stable(synth_cfg[0]))
        else $error("unguarded control write took effect");
    unlocked_write_a: assert property (
        ok0 |=> synth_cfg[0].en == $past(bus_req.wdata[0]) &&
        synth_cfg[0].src_osc0 == ($past(bus_req.wdata[2:1]) == 2'h0) &&
        synth_cfg[0].range_high == $past(bus_req.wdata[3]) &&
        synth_cfg[0].out_halve == $past(bus_req.wdata[4]) &&
        synth_cfg[0].wide_bw == !$past(bus_req.wdata[5]))
        else $error("synth option decode wrong");
    synth_ratio_a: assert property (
        ok0 |=> synth_cfg[0].vco_num ==
        $past(dv == 4'h0 ? {m1, 1'b0} : {1'b0, m1})
        && synth_cfg[0].vco_den == $past(dv == 4'h0 ? 4'h1 : dv)
        && synth_cfg[0].in_div == $past(dv == 4'h0 ? 5'h01 : {dv, 1'b0}))
        else $error("synth ratio decode wrong");
    err_status_a: assert property (
        bad0 ##2 rd && bus_req.addr == 10'h014 |=> bus_rdata[31])
        else $error("access error not in status");
    err_pending_a: assert property (
        bad0 ##2 rd && bus_req.addr == 10'h00C |=> bus_rdata[31])
        else $error("access error not pending");
    mask_off_a: assert property (
        wr && bus_req.addr == 10'h004 && bus_req.wdata == 32'hFFFFFFFF |=> !irq)
        else $error("irq with all sources masked");
endmodule : clock_status_pll_control_properties
bind clock_status_pll_control clock_status_pll_control_properties chk_u (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .main_osc_ready(main_osc_ready), .slow_osc_ready(slow_osc_ready),
    .brownout_enabled(brownout_enabled), .supply_below(supply_below),
    .synth_cfg(synth_cfg), .irq(irq));

// *** test/clock_status_pll_control_tb_top.sv ***
// self-checking bench for the clock status block
module clock_status_pll_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, slow_tick, mo, so, be, sb, irq;
    logic [31:0] bus_rdata, q, c;
    logic [1:0] synth_fault, sleep_reenable;
    logic [9:0] a;
    clock_status_pkg::bus_req_t bus_req;
    clock_status_pkg::synth_out_t [1:0] synth_cfg;
    int bad_count, cmp_count, i, n;
    clock_status_pll_control dut_u (.core_clk(core_clk), .rst(rst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .main_osc_ready(mo),
        .slow_osc_ready(so), .brownout_enabled(be), .supply_below(sb),
        .slow_tick(slow_tick), .synth_fault(synth_fault),
        .sleep_reenable(sleep_reenable), .synth_cfg(synth_cfg), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // one bus access, q holds the answer
    task automatic acc(input logic w, input logic [9:0] ad,
        input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{1'b1, w, ad, d};
        @(posedge core_clk);
        bus_req <= '0;
        #1 q = bus_rdata;
    endtask : acc
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge core_clk);
            slow_tick <= 1'b1;
            @(posedge core_clk);
            slow_tick <= 1'b0;
        end
    endtask : tick
    function automatic clock_status_pkg::synth_out_t cfg(
        input logic [31:0] w);
        logic [4:0] m;
        m = {1'b0, w[19:16]} + 5'h01;
        cfg = {w[0], w[2:1] == 2'h0, w[3], w[4], !w[5],
            w[11:8] == 4'h0 ? {m, 1'b0} : {1'b0, m},
            w[11:8] == 4'h0 ? 4'h1 : w[11:8],
            w[11:8] == 4'h0 ? 5'h01 : {w[11:8], 1'b0}};
    endfunction : cfg
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h199D4BB2));
        {rst, slow_tick, mo, so, be, sb} = 6'h20;
        {synth_fault, sleep_reenable} = 4'h0;
        bus_req = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        // reset values, write-only and unmapped places
        for (i = 0; i < 10; i++) begin
            acc(1'b0, 10'(i * 4), 32'h0);
            chk("reset", q, 32'h0);
        end
        // random oscillator and brownout levels
        for (i = 0; i < 12; i++) begin
            c = $urandom;
            @(posedge core_clk);
            {mo, so, be, sb} <= c[3:0];
            repeat (3) @(posedge core_clk);
            acc(1'b0, 10'h014, 32'h0);
            chk("status", q & 32'h13,
                {27'h0, c[1] & c[0], 2'h0, c[2], c[3]});
        end
        // pending clear, mask and irq
        @(posedge core_clk);
        mo <= 1'b0;
        acc(1'b1, 10'h010, 32'hFFFFFFFF);
        acc(1'b0, 10'h00C, 32'h0);
        chk("pending", q, 32'h0);
        @(posedge core_clk);
        mo <= 1'b1;
        acc(1'b1, 10'h010, 32'hFFFFFFFE);
        acc(1'b0, 10'h00C, 32'h0);
        chk("pending", q, 32'h1);
        acc(1'b1, 10'h000, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        acc(1'b1, 10'h010, 32'h1);
        chk("irq", 32'(irq), 32'h0);
        acc(1'b1, 10'h004, 32'hFFFFFFFF);
        acc(1'b0, 10'h008, 32'h0);
        chk("mask", q, 32'h0);
        // keyed control writes, lock wait, fault
        for (i = 0; i < 2; i++) begin
            a = i ? 10'h020 : 10'h01C;
            n = $urandom_range(6, 2);
            c = {2'h0, 6'(n), 4'h0, 4'($urandom_range(15, 2)), 4'h0,
                4'($urandom), 2'h0, 3'($urandom), 3'h1};
            acc(1'b1, 10'h018, {8'hAA, 14'h0, a});
            acc(1'b1, a, c);
            acc(1'b0, a, 32'h0);
            chk("control", q, c);
            chk("config", 32'(synth_cfg[i]),
                32'(cfg(c)));
            tick(n - 1);
            acc(1'b0, 10'h014, 32'h0);
            chk("early lock", 32'(q[2 + i]), 32'h0);
            tick(1);
            acc(1'b0, 10'h014, 32'h0);
            chk("lock", 32'(q[2 + i]), 32'h1);
            @(posedge core_clk);
            synth_fault[i] <= 1'b1;
            repeat (3) @(posedge core_clk);
            acc(1'b0, 10'h014, 32'h0);
            chk("lost", 32'({q[5 + i], q[2 + i]}), 32'h2);
            @(posedge core_clk);
            synth_fault <= 2'h0;
        end
        // wrong key and bare writes are refused
        acc(1'b0, 10'h01C, 32'h0);
        c = q;
        acc(1'b1, 10'h018, {8'hAB, 14'h0, 10'h01C});
        acc(1'b1, 10'h01C, ~c);
        acc(1'b0, 10'h014, 32'h0);
        chk("error", 32'(q[31]), 32'h1);
        acc(1'b1, 10'h01C, ~c);
        acc(1'b0, 10'h00C, 32'h0);
        chk("error pending", 32'(q[31]), 32'h1);
        acc(1'b0, 10'h01C, 32'h0);
        chk("kept", q, c);
        // sleep exit pulse restarts the lock wait of synth0
        acc(1'b0, 10'h01C, 32'h0);
        n = q[29:24];
        @(posedge core_clk);
        sleep_reenable <= 2'h1;
        @(posedge core_clk);
        sleep_reenable <= 2'h0;
        acc(1'b0, 10'h014, 32'h0);
        chk("reenable", 32'(q[2]), 32'h0);
        tick(n);
        acc(1'b0, 10'h014, 32'h0);
        chk("relock", 32'(q[2]), 32'h1);
        wrap_up();
    end
endmodule : clock_status_pll_control_tb_top
